// >>> hw/fps_status.sv
// Program/erase status register, suspend tracking and status read path
`default_nettype none

module fps_status (
	input wire logic ref_clk,
	input wire logic rst_b,
	// First write of each command, with its code
	input wire logic cmd_wr,
	input wire logic [7:0] cmd_byte,
	// Program or erase request once its last write is taken
	input wire fps_pkg::fps_op_req_type op_req,
	// Multiplexed-address programming port is in use
	input wire logic aa_mux_mode,
	// Bus read strobe and the data the array side would return
	input wire logic bus_rd,
	input wire logic [7:0] array_rd_data,
	// Answers from the embedded algorithm engine
	input wire fps_pkg::fps_eng_rsp_type eng_rsp,
	// Commands to the embedded algorithm engine
	output fps_pkg::fps_eng_cmd_type eng_cmd_q,
	// Read answer, valid one cycle after the strobe
	output logic [7:0] rd_data_q,
	output logic rd_valid_q,
	// High while reads are served from the status byte
	output logic status_mode_q,
	// Status byte as seen by the bus, one cycle behind
	output logic [7:0] status_q
);
	import fps_pkg::*;

	fps_cmd_type cmd;
	fps_err_type err_q;
	fps_err_type err_set;
	fps_state_type state_q;
	fps_state_type state_d;
	fps_rmode_type rmode_q;
	fps_rmode_type rmode_d;
	logic cur_erase_q;
	logic nested_q;
	logic erase_susp_q;
	logic prog_susp_q;
	logic start_ok;
	logic start_bad;
	logic start_allowed;
	logic prot_hit;
	logic vpp_bad;
	logic done_fail;
	logic [7:0] status_now;

	// A resume counts only for a parked operation that is not nested
	function automatic logic resume_taken(input fps_state_type st,
		input logic res, input logic nest);
		resume_taken = (st == ST_PAUSED) && res && !nest;
	endfunction

	// The engine has parked rather than finished after a suspend
	function automatic logic pause_landed(input fps_state_type st,
		input fps_eng_rsp_type rsp);
		pause_landed = (st == ST_PAUSING) && rsp.paused && !rsp.done;
	endfunction

	// Command byte decode
	fps_cmd_decode u_decode (
		.cmd_wr(cmd_wr),
		.cmd_byte(cmd_byte),
		.cmd(cmd)
	);

	// Error flag storage
	fps_sticky_flags u_flags (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.set_vec(err_set),
		.clear_all(cmd.clear),
		.flags_q(err_q)
	);

	// A new operation may start when idle, or as a program inside an
	// erase suspend; anything else is left to the sequencer to refuse
	always_comb begin
		start_allowed = 1'b0;
		if (op_req.start) begin
			if (state_q == ST_IDLE) begin
				start_allowed = 1'b1;
			end else if (state_q == ST_PAUSED && erase_susp_q
				&& !nested_q && !op_req.is_erase) begin
				start_allowed = 1'b1; // see [R20]
			end
		end
	end

	// Voltage and protection are judged only at the moment of start;
	// a later sag is not seen here, which the engine must live with
	always_comb begin
		vpp_bad = start_allowed && !op_req.vpp_ok; // see [R11]
		prot_hit = start_allowed && op_req.block_locked
			&& !aa_mux_mode; // see [R15]
		start_bad = vpp_bad || prot_hit;
		start_ok = start_allowed && !start_bad;
	end

	// Verification failure reported by the engine on completion
	always_comb begin
		done_fail = eng_rsp.done && eng_rsp.fail
			&& (state_q == ST_BUSY || state_q == ST_PAUSING);
	end

	// Error events; a refused start also marks the operation failed
	always_comb begin
		err_set = ERR_NONE;
		err_set.vpp_err = vpp_bad; // see [R11]
		err_set.prot_err = prot_hit; // see [R15]
		if (start_bad) begin
			if (op_req.is_erase) begin
				err_set.erase_fail = 1'b1; // see [R19]
			end else begin
				err_set.program_fail = 1'b1; // see [R18]
			end
		end
		if (done_fail) begin
			if (cur_erase_q) begin
				err_set.erase_fail = 1'b1; // see [R09]
			end else begin
				err_set.program_fail = 1'b1; // see [R10]
			end
		end
	end

	// Controller state; a suspend inside a nested program is ignored
	// because the erase is already parked underneath it
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (start_ok) begin
					state_d = ST_BUSY;
				end
			end
			ST_BUSY: begin
				if (eng_rsp.done) begin
					state_d = nested_q ? ST_PAUSED : ST_IDLE;
				end else if (cmd.suspend && !nested_q) begin
					state_d = ST_PAUSING; // see [R04]
				end
			end
			ST_PAUSING: begin
				if (eng_rsp.done) begin
					state_d = ST_IDLE; // see [R08]
				end else if (eng_rsp.paused) begin
					state_d = ST_PAUSED; // see [R04]
				end
			end
			ST_PAUSED: begin
				if (start_ok) begin
					state_d = ST_BUSY;
				end else if (cmd.resume && !nested_q) begin
					state_d = ST_BUSY;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= ST_IDLE; // see [R23]
		end else begin
			state_q <= state_d;
		end
	end

	// Kind of the operation the engine is running
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cur_erase_q <= 1'b0;
		end else if (start_ok) begin
			cur_erase_q <= op_req.is_erase;
		end else if (state_q == ST_BUSY && eng_rsp.done && nested_q) begin
			// Back to the parked erase once the nested program ends
			cur_erase_q <= 1'b1;
		end
	end

	// Marks a program running on top of a suspended erase
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			nested_q <= 1'b0;
		end else if (state_q == ST_PAUSED && start_ok) begin
			nested_q <= 1'b1; // see [R20]
		end else if (state_q == ST_BUSY && eng_rsp.done) begin
			nested_q <= 1'b0;
		end
	end

	// Erase-suspended flag stays up through a nested program
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			erase_susp_q <= 1'b0; // see [R23]
		end else if (resume_taken(state_q, cmd.resume, nested_q)) begin
			erase_susp_q <= 1'b0; // see [R07]
		end else if (pause_landed(state_q, eng_rsp) && cur_erase_q) begin
			erase_susp_q <= 1'b1; // see [R06]
		end
	end

	// Program-suspended flag; finishing instead of pausing leaves it 0
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			prog_susp_q <= 1'b0; // see [R23]
		end else if (resume_taken(state_q, cmd.resume, nested_q)) begin
			prog_susp_q <= 1'b0; // see [R14]
		end else if (pause_landed(state_q, eng_rsp) && !cur_erase_q) begin
			prog_susp_q <= 1'b1; // see [R14]
		end
	end

	// Engine commands are registered pulses so the engine sees clean
	// one-cycle strobes regardless of the decode timing
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			eng_cmd_q <= ENG_CMD_NONE;
		end else begin
			eng_cmd_q.go <= start_ok;
			eng_cmd_q.is_erase <= start_ok ? op_req.is_erase : 1'b0;
			eng_cmd_q.suspend <= state_q == ST_BUSY && state_d == ST_PAUSING;
			eng_cmd_q.resume <= !start_ok
				&& resume_taken(state_q, cmd.resume, nested_q);
		end
	end

	// Read source; an operation request switches to status even when
	// refused, so the host always sees why it failed
	always_comb begin
		rmode_d = rmode_q;
		if (op_req.start) begin
			rmode_d = RM_STATUS; // see [R02]
		end else if (cmd.resume) begin
			rmode_d = RM_STATUS; // see [R02]
		end else if (cmd.rd_status) begin
			rmode_d = RM_STATUS; // see [R22]
		end else if (cmd.rd_array) begin
			rmode_d = RM_ARRAY;
		end else if (cmd.other) begin
			rmode_d = RM_OTHER;
		end
	end

	// Read mode register; status reads persist until a read-array or unrecognised command
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rmode_q <= RM_ARRAY;
		end else begin
			rmode_q <= rmode_d;
		end
	end

	// Assemble the status byte from live state and stored flags
	always_comb begin
		status_now = STATUS_RESET;
		status_now[IDLE_POS] = state_q == ST_IDLE
			|| state_q == ST_PAUSED; // see [R03]
		status_now[ERASE_SUSP_POS] = erase_susp_q; // see [R06]
		status_now[ERASE_FAIL_POS] = err_q.erase_fail; // see [R19]
		status_now[PROG_FAIL_POS] = err_q.program_fail; // see [R18]
		status_now[VPP_ERR_POS] = err_q.vpp_err; // see [R13]
		status_now[PROG_SUSP_POS] = prog_susp_q; // see [R14]
		status_now[PROT_ERR_POS] = err_q.prot_err
			&& !aa_mux_mode; // see [R16]
		status_now[RSVD_POS] = RSVD_VALUE;
	end

	// Visible copy of the status byte
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			status_q <= STATUS_RESET; // see [R23]
		end else begin
			status_q <= status_now;
		end
	end

	// Status mode flag for the surrounding read mux
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			status_mode_q <= 1'b0;
		end else begin
			status_mode_q <= rmode_d == RM_STATUS;
		end
	end

	// Read answer; no address enters the status path at all
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_data_q <= RD_DATA_RESET;
		end else if (bus_rd) begin
			if (rmode_q == RM_STATUS) begin
				rd_data_q <= status_now; // see [R01]
			end else begin
				rd_data_q <= array_rd_data;
			end
		end
	end

	// One-cycle valid that follows every read strobe
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_valid_q <= 1'b0;
		end else begin
			rd_valid_q <= bus_rd;
		end
	end

endmodule

`default_nettype wire

// >>> common/fps_pkg.sv
// Constants and carrier types for the flash program/erase status logic
//
// Functional notes
// [R01] Status reads ignore the presented address.
// [R02] Program, erase, resume switch reads to status.
// [R03] Bit 7 is 0 busy, 1 idle.
// [R04] After suspend, bit 7 stays 0 until paused.
// [R05] Host polls bit 7, then checks errors.
// [R06] Bit 6 marks an erase awaiting resume.
// [R07] Resume clears the erase-suspended bit.
// [R08] Suspend may finish instead; flags stay 0.
// [R09] Bit 5 set on failed erase verification.
// [R10] Bit 4 set on failed program verification.
// [R11] Voltage sampled at start; bad sets bit 3.
// [R12] Error bits hold until clear or reset.
// [R13] Uncleared errors make next operation look failed.
// [R14] Bit 2 marks program suspended; resume clears.
// [R15] Bit 1 set on protected block attempt.
// [R16] Multiplexed-address port: bit 1 reads 0.
// [R17] Bit 0 reserved; host masks it.
// [R18] Failed program: bits 7, 4, cause bits.
// [R19] Failed erase: bits 7, 5, bit 6 low.
// [R20] Program within erase suspend shows bit 6.
// [R21] Command 50h clears bits 1, 3, 4, 5.
// [R22] Command 70h makes reads return status.
// [R23] Reset shows idle with all flags 0.
`default_nettype none

package fps_pkg;

	// Status byte field positions
	localparam int unsigned IDLE_POS = 7;
	localparam int unsigned ERASE_SUSP_POS = 6;
	localparam int unsigned ERASE_FAIL_POS = 5;
	localparam int unsigned PROG_FAIL_POS = 4;
	localparam int unsigned VPP_ERR_POS = 3;
	localparam int unsigned PROG_SUSP_POS = 2;
	localparam int unsigned PROT_ERR_POS = 1;
	localparam int unsigned RSVD_POS = 0;

	// Reset and fixed values
	localparam logic [7:0] STATUS_RESET = 8'h80;
	localparam logic RSVD_VALUE = 1'b0;
	localparam logic [7:0] RD_DATA_RESET = 8'h00;

	// Command codes seen on the first write of a command
	localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
	localparam logic [7:0] CMD_SUSPEND = 8'hb0;
	localparam logic [7:0] CMD_RESUME = 8'hd0;

	// Sticky error flags, one bit each
	typedef struct packed {
		logic erase_fail;
		logic program_fail;
		logic vpp_err;
		logic prot_err;
	} fps_err_type;

	localparam fps_err_type ERR_NONE = '{default: 1'b0};

	// Decoded one-cycle command events
	typedef struct packed {
		logic rd_array;
		logic rd_status;
		logic clear;
		logic suspend;
		logic resume;
		logic other;
	} fps_cmd_type;

	// Operation start request from the command sequencer
	typedef struct packed {
		logic start;
		logic is_erase;
		logic block_locked;
		logic vpp_ok;
	} fps_op_req_type;

	// Answers from the embedded algorithm engine
	typedef struct packed {
		logic done;
		logic fail;
		logic paused;
	} fps_eng_rsp_type;

	// Commands to the embedded algorithm engine, all one-cycle pulses
	typedef struct packed {
		logic go;
		logic is_erase;
		logic suspend;
		logic resume;
	} fps_eng_cmd_type;

	localparam fps_eng_cmd_type ENG_CMD_NONE = '{default: 1'b0};

	// Controller states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_BUSY,
		ST_PAUSING,
		ST_PAUSED
	} fps_state_type;

	// Where bus reads are served from
	typedef enum logic [1:0] {
		RM_ARRAY,
		RM_STATUS,
		RM_OTHER
	} fps_rmode_type;

endpackage

`default_nettype wire

// >>> hw/fps_cmd_decode.sv
// Command byte decoder turning a command write into event pulses
`default_nettype none

module fps_cmd_decode (
	input wire logic cmd_wr,
	input wire logic [7:0] cmd_byte,
	output fps_pkg::fps_cmd_type cmd
);
	import fps_pkg::*;

	// True when a write carries the given command code
	function automatic logic hit(input logic wr, input logic [7:0] b,
		input logic [7:0] code);
		hit = wr && (b == code);
	endfunction

	// Every write decodes to exactly one event, unknown codes to other
	always_comb begin
		cmd.rd_array = hit(cmd_wr, cmd_byte, CMD_READ_ARRAY);
		cmd.rd_status = hit(cmd_wr, cmd_byte, CMD_READ_STATUS);
		cmd.clear = hit(cmd_wr, cmd_byte, CMD_CLEAR_STATUS);
		cmd.suspend = hit(cmd_wr, cmd_byte, CMD_SUSPEND);
		cmd.resume = hit(cmd_wr, cmd_byte, CMD_RESUME);
		cmd.other = cmd_wr && !(cmd.rd_array || cmd.rd_status
			|| cmd.clear || cmd.suspend || cmd.resume);
	end

endmodule

`default_nettype wire

// >>> hw/fps_sticky_flags.sv
// Sticky error flags with a common clear where setting wins
`default_nettype none

module fps_sticky_flags (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire fps_pkg::fps_err_type set_vec,
	input wire logic clear_all,
	output fps_pkg::fps_err_type flags_q
);
	import fps_pkg::*;

	fps_err_type flags_d;

	// An event in the clearing cycle survives, so no failure is lost
	always_comb begin
		flags_d = clear_all ? ERR_NONE : flags_q; // see [R21]
		flags_d = flags_d | set_vec; // see [R12]
	end

	// Flags leave 1 only through a clear or a hardware reset
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			flags_q <= ERR_NONE; // see [R23]
		end else begin
			flags_q <= flags_d;
		end
	end

endmodule

`default_nettype wire

// >>> tb/fps_status_checker.sv
// Assertions on the ports of the program/erase status logic
`default_nettype none
module fps_status_checker (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic cmd_wr,
	input wire logic [7:0] cmd_byte,
	input wire fps_pkg::fps_op_req_type op_req,
	input wire logic aa_mux_mode,
	input wire logic bus_rd,
	input wire logic [7:0] array_rd_data,
	input wire fps_pkg::fps_eng_rsp_type eng_rsp,
	input wire fps_pkg::fps_eng_cmd_type eng_cmd_q,
	input wire logic [7:0] rd_data_q,
	input wire logic rd_valid_q,
	input wire logic status_mode_q,
	input wire logic [7:0] status_q
);
	timeunit 1ns;
	timeprecision 1ns;
	import fps_pkg::*;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);
	// Voltage-refused start while idle; status_q lags the state by one
	sequence s_bad_vpp;
		op_req.start && !op_req.vpp_ok && status_q[7] && !status_q[6]
			&& !status_q[2];
	endsequence
	// Clear with no competing set, since a set wins in the same cycle
	sequence s_clear;
		cmd_wr && cmd_byte == CMD_CLEAR_STATUS && !op_req.start
			&& !eng_rsp.done;
	endsequence
	AST_RST: assert property (!$past(rst_b) |-> status_q == 8'h80)
		else $error("status not idle after reset");
	AST_RD: assert property (bus_rd |=> rd_valid_q)
		else $error("read not answered");
	AST_MODE: assert property (op_req.start || (cmd_wr &&
		(cmd_byte == CMD_READ_STATUS || cmd_byte == CMD_RESUME))
		|=> status_mode_q) else $error("status read mode not entered");
	AST_RDST: assert property (bus_rd && status_mode_q
		|=> rd_data_q == status_q) else $error("read is not status");
	AST_AAMUX: assert property (bus_rd && status_mode_q
		&& aa_mux_mode |=> !rd_data_q[1])
		else $error("protection bit seen on mux port");
	AST_VPP: assert property (s_bad_vpp |=>
		!eng_cmd_q.go ##1 status_q[3]) else $error("bad voltage not flagged");
	AST_BUSY: assert property (eng_cmd_q.go |=> !status_q[7])
		else $error("busy not shown");
	AST_SUSP: assert property (eng_cmd_q.suspend |=> !status_q[7])
		else $error("idle before pause");
	AST_PAUSE: assert property (eng_rsp.paused |-> ##2
		status_q[7] && (status_q[6] || status_q[2]))
		else $error("pause not shown");
	AST_RESUME: assert property (eng_cmd_q.resume |=>
		status_q[7:6] == 2'b00 && !status_q[2]) else $error("resume flags");
	AST_CLEAR: assert property (s_clear |-> ##2
		status_q[5:3] == 3'b000 && !status_q[1])
		else $error("clear did not clear");
	AST_FAIL: assert property (eng_rsp.done && eng_rsp.fail
		|-> ##2 status_q[7] && (status_q[5] || status_q[4]))
		else $error("no fail");
	// The engine is told the kind of operation only together with go
	AST_KIND: assert property (eng_cmd_q.is_erase ==
		(eng_cmd_q.go && $past(op_req.is_erase)))
		else $error("engine kind wrong");
endmodule
bind fps_status fps_status_checker chk (.ref_clk(ref_clk), .rst_b(rst_b),
	.cmd_wr(cmd_wr), .cmd_byte(cmd_byte), .op_req(op_req),
	.aa_mux_mode(aa_mux_mode), .bus_rd(bus_rd),
	.array_rd_data(array_rd_data), .eng_rsp(eng_rsp),
	.eng_cmd_q(eng_cmd_q), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
	.status_mode_q(status_mode_q), .status_q(status_q));
`default_nettype wire

// >>> tb/fps_engine_model.sv
// Behavioural embedded algorithm engine facing the status logic
`default_nettype none
module fps_engine_model (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire fps_pkg::fps_eng_cmd_type eng_cmd_q,
	input wire logic fail_en,
	input wire logic fin_susp,
	output fps_pkg::fps_eng_rsp_type eng_rsp
);
	timeunit 1ns;
	timeprecision 1ns;
	import fps_pkg::*;
	int cnt;
	logic susp;
	// Run countdown; a suspend ends it early in a pause or a finish
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= 0;
			susp <= 1'b0;
			eng_rsp <= '0;
		end else begin
			eng_rsp <= '0;
			if (eng_cmd_q.go || eng_cmd_q.resume) begin
				cnt <= 12;
				susp <= 1'b0;
			end else if (eng_cmd_q.suspend) begin
				cnt <= 3;
				susp <= !fin_susp;
			end else if (cnt == 1) begin
				cnt <= 0;
				eng_rsp.done <= !susp;
				eng_rsp.fail <= fail_en & !susp;
				eng_rsp.paused <= susp;
			end else if (cnt != 0) begin
				cnt <= cnt - 1;
			end
		end
	end
endmodule
`default_nettype wire

// >>> tb/fps_status_tb_top.sv
// Self-checking bench for the program/erase status logic
`default_nettype none
module fps_status_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import fps_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic cmd_wr = 1'b0;
	logic [7:0] cmd_byte = 8'h00;
	fps_op_req_type op_req = '0;
	logic aa_mux_mode = 1'b0;
	logic bus_rd = 1'b0;
	logic [7:0] array_rd_data = 8'h5a;
	logic fail_en = 1'b0;
	logic fin_susp = 1'b0;
	fps_eng_rsp_type eng_rsp;
	fps_eng_cmd_type eng_cmd_q;
	logic [7:0] rd_data_q;
	logic [7:0] status_q;
	logic rd_valid_q;
	logic status_mode_q;
	int fail_count = 0;
	int n_compared = 0;
	// 50 MHz clock
	always #10 ref_clk = ~ref_clk;
	fps_status dut (.ref_clk(ref_clk), .rst_b(rst_b), .cmd_wr(cmd_wr),
		.cmd_byte(cmd_byte), .op_req(op_req), .aa_mux_mode(aa_mux_mode),
		.bus_rd(bus_rd), .array_rd_data(array_rd_data), .eng_rsp(eng_rsp),
		.eng_cmd_q(eng_cmd_q), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
		.status_mode_q(status_mode_q), .status_q(status_q));
	fps_engine_model eng (.ref_clk(ref_clk), .rst_b(rst_b),
		.eng_cmd_q(eng_cmd_q), .fail_en(fail_en), .fin_susp(fin_susp),
		.eng_rsp(eng_rsp));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic cmd(input logic [7:0] b);
		@(negedge ref_clk);
		cmd_wr = 1'b1;
		cmd_byte = b;
		@(negedge ref_clk);
		cmd_wr = 1'b0;
	endtask
	task automatic start(input logic e, input logic lk, input logic v);
		@(negedge ref_clk);
		op_req = '{1'b1, e, lk, v};
		@(negedge ref_clk);
		op_req = '0;
	endtask
	// One read strobe; bit 0 is masked as the host must do
	task automatic rd(input logic [7:0] exp);
		@(negedge ref_clk);
		bus_rd = 1'b1;
		@(negedge ref_clk);
		bus_rd = 1'b0;
		chk({7'h00, rd_valid_q}, 8'h01);
		chk(rd_data_q & 8'hfe, exp);
	endtask
	// Poll until idle under a bound, then judge the other bits
	task automatic poll(input logic [7:0] exp);
		int i;
		i = 0;
		do begin
			@(negedge ref_clk);
			bus_rd = 1'b1;
			@(negedge ref_clk);
			bus_rd = 1'b0;
			i++;
		end while (rd_data_q[7] !== 1'b1 && i < 60);
		if (rd_data_q[7] !== 1'b1) begin
			// A controller that never goes idle counts as one mismatch
			fail_count++;
			summarize();
		end else begin
			chk(rd_data_q & 8'hfe, exp);
		end
	endtask
	// Array reads after reset, then status, then an unknown code
	task automatic t_reset();
		rd(8'h5a);
		cmd(CMD_READ_STATUS);
		chk({7'h00, status_mode_q}, 8'h01);
		array_rd_data = 8'h34;
		rd(8'h80);
		cmd(8'h60);
		chk({7'h00, status_mode_q}, 8'h00);
		rd(8'h34);
	endtask
	task automatic t_fail();
		cmd(CMD_READ_ARRAY);
		start(1'b0, 1'b0, 1'b1);
		rd(8'h00);
		poll(8'h80);
		fail_en = 1'b1;
		start(1'b1, 1'b0, 1'b1);
		poll(8'ha0);
		fail_en = 1'b0;
		start(1'b0, 1'b0, 1'b1);
		poll(8'ha0);
		cmd(CMD_CLEAR_STATUS);
		rd(8'h80);
		fail_en = 1'b1;
		start(1'b0, 1'b0, 1'b1);
		poll(8'h90);
		fail_en = 1'b0;
		cmd(CMD_CLEAR_STATUS);
	endtask
	task automatic t_refused();
		start(1'b0, 1'b0, 1'b0);
		rd(8'h98);
		cmd(CMD_CLEAR_STATUS);
		start(1'b1, 1'b0, 1'b0);
		rd(8'ha8);
		cmd(CMD_CLEAR_STATUS);
		start(1'b0, 1'b1, 1'b1);
		rd(8'h92);
		aa_mux_mode = 1'b1;
		rd(8'h90);
		cmd(CMD_CLEAR_STATUS);
		start(1'b1, 1'b1, 1'b1);
		poll(8'h80);
		aa_mux_mode = 1'b0;
	endtask
	task automatic t_suspend();
		start(1'b1, 1'b0, 1'b1);
		cmd(CMD_SUSPEND);
		rd(8'h00);
		poll(8'hc0);
		start(1'b0, 1'b0, 1'b1);
		rd(8'h40);
		poll(8'hc0);
		cmd(CMD_RESUME);
		rd(8'h00);
		poll(8'h80);
		start(1'b0, 1'b0, 1'b1);
		cmd(CMD_SUSPEND);
		poll(8'h84);
		cmd(CMD_RESUME);
		rd(8'h00);
		poll(8'h80);
		fin_susp = 1'b1;
		start(1'b1, 1'b0, 1'b1);
		cmd(CMD_SUSPEND);
		poll(8'h80);
		fin_susp = 1'b0;
	endtask
	// Errors are set, then a hardware reset in mid-run wipes them
	task automatic t_midreset();
		start(1'b0, 1'b0, 1'b0);
		rd(8'h98);
		@(negedge ref_clk);
		rst_b = 1'b0;
		repeat (3) @(negedge ref_clk);
		rst_b = 1'b1;
		chk(rd_data_q, 8'h00);
		chk({7'h00, status_mode_q}, 8'h00);
		rd(8'h34);
		cmd(CMD_READ_STATUS);
		rd(8'h80);
	endtask
	// Reset for 20 cycles, then the scenarios in turn
	initial begin
		repeat (20) @(negedge ref_clk);
		rst_b = 1'b1;
		t_reset();
		t_fail();
		t_refused();
		t_suspend();
		t_midreset();
		summarize();
	end
endmodule
`default_nettype wire
